// ==== hw/spi_cfg.svh ====
// Purpose: Constants for the serial controller: offsets, fields, resets, rates
// Assumes: Included by the package and the design file
// Notes:   Offsets are register indices; byte address is four times the index
`ifndef SPI_CFG_SVH
`define SPI_CFG_SVH

`define IDX_DATA        8'h61
`define IDX_CTRL        8'h62
`define IDX_CSR         8'h63
`define IDX_PWR         8'h64
`define ADDR_W          12

`define CR_IE           7
`define CR_PE           6
`define CR_DIVEN        5
`define CR_MASTER_SELECT_BIT         4
`define CR_CLOCK_POLARITY_BIT         3
`define CR_CLOCK_PHASE_BIT         2
`define CR_RATE1        1
`define CR_RATE0        0

`define CS_TC           7
`define CS_WRITE_COLLISION_FLAG         6
`define CS_OVR          5
`define CS_MODE_FAULT_FLAG         4
`define CS_SOD          2
`define CS_SSM          1
`define CS_SSI          0
`define CS_SW_MASK      8'h07

`define PWR_WAIT        0
`define PWR_HALT        1
`define PWR_GIE         2

`define CR_RESET        8'h00
`define CS_RESET        8'h00
`define DIV_W           7
`define BIT_LAST        3'h7
`define BIT_FIRST       3'h0

`endif

// ==== hw/spi_pkg.sv ====
// Purpose: Types for the serial controller
// Assumes: Constants come from spi_cfg.svh
// Notes:   Types only
`include "spi_cfg.svh"
package spi_pkg;

	// Serial pins towards the link
	typedef struct packed {
		logic sck_o;
		logic sck_oen_n;
		logic mosi_o;
		logic mosi_oen_n;
		logic miso_o;
		logic miso_oen_n;
	} spi_pins_type;

	// Shift engine states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LEAD,
		ST_TRAIL
	} shift_state_type;

endpackage

// ==== hw/spi_master_slave_controller.sv ====
// Purpose: Byte-wide serial controller, master or slave, APB register port
// Assumes: All inputs synchronous to pclk; link pins sampled directly
// Notes:   Low-power state driven through an extra power register
// Behaviour
// - Wait state leaves serial engine running; wakes
// - Halt freezes engine and registers until wake
// - Several bytes while halted set overrun; the code drops them and leaves the flag unchanged
// - Slave can wake from halt via transfer-complete
// - Halt wake needs select low at entry
// - Shared request gated by enable and mask
// - Interrupt enable gates complete, fault, overrun
// - Peripheral enable cleared by reset, fault
// - Rate bits pick clock divide 4..128
// - Master bit drives clock, swaps data pins
// - Polarity sets clock idle level
// - Phase picks first or second capture edge
// - Complete flag set at byte end, sequence-cleared
// - Data writes ignored while complete set, unread
// - Write during transfer sets collision flag
// - Overrun when byte arrives, complete still set
// - Mode fault on select low in master
// - Output disable turns off data output
// - Soft select replaces select pin
// - Data write loads shifter, starts master
// - Received byte copied to read buffer
// - Bytes shift out most significant first
// - Overrun keeps first byte, discards later
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spi_cfg.svh"

module spi_master_slave_controller #(
	parameter int DATA_W = 8
) (
	// APB slave
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [`ADDR_W-1:0]   paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Link pins
	input  wire logic                 sck_i,
	input  wire logic                 mosi_i,
	input  wire logic                 miso_i,
	input  wire logic                 ss_n_i,
	output spi_pkg::spi_pins_type     pins,
	// Core side
	output logic                      irq,
	output logic                      wake
);
	import spi_pkg::*;

	logic [7:0]        ctrl_ff;
	logic [7:0]        csr_ff;
	logic [2:0]        pwr_ff;
	logic [7:0]        rxbuf_ff;
	logic [7:0]        shift_ff;
	logic [2:0]        bitcnt_ff;
	logic [`DIV_W-1:0] div_ff;
	logic              sck_prev_ff;
	logic              rx_bit_ff;
	logic              cs_seen_ff;
	logic              mf_seen_ff;
	logic              rx_latch_ff;
	logic              halt_ok_ff;
	shift_state_type   state_ff;

	// Decode and effective controls
	wire        halted   = pwr_ff[`PWR_HALT];
	wire        run      = !halted;
	wire        master   = ctrl_ff[`CR_MASTER_SELECT_BIT];
	wire        enabled  = ctrl_ff[`CR_PE];
	wire        clock_polarity_bit     = ctrl_ff[`CR_CLOCK_POLARITY_BIT];
	wire        clock_phase_bit     = ctrl_ff[`CR_CLOCK_PHASE_BIT];
	wire        ss_int_n = csr_ff[`CS_SSM] ? csr_ff[`CS_SSI] : ss_n_i;
	wire        setup    = psel && !penable;
	wire        acc      = psel && penable;
	wire [9:0]  idx      = paddr[`ADDR_W-1:2];
	wire        hit_data = idx == 10'(`IDX_DATA);
	wire        hit_ctrl = idx == 10'(`IDX_CTRL);
	wire        hit_csr  = idx == 10'(`IDX_CSR);
	wire        hit_pwr  = idx == 10'(`IDX_PWR);
	wire        mapped   = hit_data || hit_ctrl || hit_csr || hit_pwr;
	wire        wr_data  = acc && pwrite && hit_data;
	wire        rd_data  = acc && !pwrite && hit_data;
	wire        wr_ctrl  = acc && pwrite && hit_ctrl;
	wire        csr_acc  = acc && hit_csr;
	wire        busy     = state_ff != ST_IDLE;

	// rate table: diven,rate1,rate0 -> half-period in pclk cycles
	function automatic logic [`DIV_W-1:0] half_period(input logic [2:0] sel);
		case (sel)
			3'h4:    half_period = 7'h02;
			3'h0:    half_period = 7'h04;
			3'h1:    half_period = 7'h08;
			3'h6:    half_period = 7'h10;
			3'h2:    half_period = 7'h20;
			3'h3:    half_period = 7'h40;
			3'h5:    half_period = 7'h08;
			default: half_period = 7'h40;
		endcase
	endfunction

	wire [`DIV_W-1:0] half = half_period({ctrl_ff[`CR_DIVEN], ctrl_ff[1:0]});
	wire              tick = master && busy && (div_ff == half - 7'h01);

	// Slave clock edges; idle level follows polarity
	wire sck_lvl   = sck_i ^ clock_polarity_bit;
	wire s_lead    = !master && enabled && !ss_int_n && !sck_prev_ff && sck_lvl;
	wire s_trail   = !master && enabled && !ss_int_n && sck_prev_ff && !sck_lvl;
	wire lead_ev   = master ? (tick && state_ff == ST_LEAD) : s_lead;
	wire trail_ev  = master ? (tick && state_ff == ST_TRAIL) : s_trail;
	// clock_phase_bit 0 samples on leading edge, 1 on trailing
	wire samp_ev   = clock_phase_bit ? trail_ev : lead_ev;
	wire shft_ev   = clock_phase_bit ? lead_ev : trail_ev;
	wire din       = master ? miso_i : mosi_i;
	wire byte_done = samp_ev && bitcnt_ff == `BIT_LAST;
	wire mf_event  = master && enabled && !ss_n_i && !csr_ff[`CS_SSM];

	// Load accepted only when idle and not blocked by complete flag
	wire load_ok   = wr_data && !(csr_ff[`CS_TC] && !cs_seen_ff) && !busy;

	// Edge history for slave clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_prev_ff <= 1'b0;
		end else if (run) begin
			sck_prev_ff <= sck_lvl;
		end
	end

	// Baud divider; counts while busy, only a master ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_ff <= '0;
		else if (!busy || tick || !run)
			div_ff <= '0;
		else
			div_ff <= div_ff + 7'h01;
	end

	// Shift state machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff  <= ST_IDLE;
			bitcnt_ff <= `BIT_FIRST;
		end else if (run) begin
			case (state_ff)
				ST_IDLE: begin
					bitcnt_ff <= `BIT_FIRST;
					if ((load_ok && master && enabled) || s_lead)
						state_ff <= s_lead ? ST_TRAIL : ST_LEAD;
				end
				ST_LEAD: begin
					if (lead_ev)
						state_ff <= ST_TRAIL;
				end
				ST_TRAIL: begin
					if (trail_ev) begin
						bitcnt_ff <= bitcnt_ff + 3'h1;
						state_ff  <= (bitcnt_ff == `BIT_LAST) ? ST_IDLE : ST_LEAD;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
			if (mf_event || !enabled || (!master && ss_int_n))
				state_ff <= ST_IDLE;
		end
	end

	// Capture on the sample edge, move on the shift edge, MSB first;
	// first lead of a phase-1 byte skipped so the MSB stays on the line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_ff    <= 8'h00;
			rx_bit_ff   <= 1'b0;
			rx_latch_ff <= 1'b0;
		end else if (run) begin
			rx_latch_ff <= byte_done;
			if (samp_ev)
				rx_bit_ff <= din;
			if (load_ok)
				shift_ff <= pwdata[7:0];
			else if (shft_ev && !(clock_phase_bit && bitcnt_ff == `BIT_FIRST))
				shift_ff <= {shift_ff[6:0], rx_bit_ff};
		end
	end

	// Receive buffer; held while complete still pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rxbuf_ff <= 8'h00;
		else if (run && rx_latch_ff && !csr_ff[`CS_TC])
			rxbuf_ff <= {shift_ff[6:0], rx_bit_ff};
	end

	// Control register; hardware clears enable and master on fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_ff <= `CR_RESET;
		else if (run) begin
			if (mf_event) begin
				ctrl_ff[`CR_PE]   <= 1'b0;
				ctrl_ff[`CR_MASTER_SELECT_BIT] <= 1'b0;
			end else if (wr_ctrl) begin
				ctrl_ff <= pwdata[7:0];
				// Enable and master held off while fault stands outside clear
				if (csr_ff[`CS_MODE_FAULT_FLAG] && !mf_seen_ff) begin
					ctrl_ff[`CR_PE]   <= 1'b0;
					ctrl_ff[`CR_MASTER_SELECT_BIT] <= 1'b0;
				end
			end
		end
	end

	// Sequence tracking for flag clearing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_seen_ff <= 1'b0;
			mf_seen_ff <= 1'b0;
		end else if (run) begin
			if (csr_ff[`CS_TC] && csr_acc)
				cs_seen_ff <= 1'b1;
			else if (!csr_ff[`CS_TC])
				cs_seen_ff <= 1'b0;
			if (csr_ff[`CS_MODE_FAULT_FLAG] && csr_acc && !pwrite)
				mf_seen_ff <= 1'b1;
			else if (!csr_ff[`CS_MODE_FAULT_FLAG])
				mf_seen_ff <= 1'b0;
		end
	end

	// Status flags; hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			csr_ff <= `CS_RESET;
		else if (run) begin
			if (acc && pwrite && hit_csr)
				csr_ff[2:0] <= 3'(pwdata[7:0] & `CS_SW_MASK);
			if (rx_latch_ff)
				csr_ff[`CS_TC] <= 1'b1;
			else if (cs_seen_ff && (wr_data || rd_data))
				csr_ff[`CS_TC] <= 1'b0;
			if (rx_latch_ff && csr_ff[`CS_TC])
				csr_ff[`CS_OVR] <= 1'b1;
			else if (csr_acc && !pwrite && prdata[`CS_OVR])
				csr_ff[`CS_OVR] <= 1'b0;
			if (wr_data && busy)
				csr_ff[`CS_WRITE_COLLISION_FLAG] <= 1'b1;
			else if (cs_seen_ff && (wr_data || rd_data))
				csr_ff[`CS_WRITE_COLLISION_FLAG] <= 1'b0;
			if (mf_event)
				csr_ff[`CS_MODE_FAULT_FLAG] <= 1'b1;
			else if (mf_seen_ff && wr_ctrl)
				csr_ff[`CS_MODE_FAULT_FLAG] <= 1'b0;
		end
	end

	// Power register; halt entry records whether select was low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_ff     <= 3'h0;
			halt_ok_ff <= 1'b0;
		end else begin
			if (acc && pwrite && hit_pwr) begin
				pwr_ff <= pwdata[2:0];
				if (pwdata[`PWR_HALT] && !halted)
					halt_ok_ff <= !ss_int_n && !master;
			end else if (wake)
				pwr_ff[1:0] <= 2'b00;
		end
	end

	// Halted slave still counts one byte so it can wake the core
	logic [2:0] hcnt_ff;
	logic       hsck_ff;
	logic       hdone_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hcnt_ff   <= 3'h0;
			hsck_ff   <= 1'b0;
			hdone_ff  <= 1'b0;
		end else if (halted && halt_ok_ff) begin
			hsck_ff <= sck_lvl;
			if ((clock_phase_bit ? (hsck_ff && !sck_lvl) : (!hsck_ff && sck_lvl)) && !hdone_ff) begin
				hcnt_ff   <= hcnt_ff + 3'h1;
				hdone_ff  <= hcnt_ff == `BIT_LAST;
			end
		end else begin
			hcnt_ff  <= 3'h0;
			hdone_ff <= 1'b0;
			hsck_ff  <= sck_lvl;
		end
	end

	// Interrupt and wake outputs
	wire evt_any = csr_ff[`CS_TC] || csr_ff[`CS_MODE_FAULT_FLAG] || csr_ff[`CS_OVR];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq  <= 1'b0;
			wake <= 1'b0;
		end else begin
			irq  <= ctrl_ff[`CR_IE] && pwr_ff[`PWR_GIE] && evt_any;
			wake <= (pwr_ff[`PWR_WAIT] && ctrl_ff[`CR_IE] && evt_any)
				|| (halted && hdone_ff && ctrl_ff[`CR_IE]);
		end
	end

	// Pin drive; output enables low while driving
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pins <= '{sck_o: 1'b0, sck_oen_n: 1'b1, mosi_o: 1'b0,
				mosi_oen_n: 1'b1, miso_o: 1'b0, miso_oen_n: 1'b1};
		else begin
			pins.sck_o      <= clock_polarity_bit ^ (master && state_ff == ST_TRAIL);
			pins.sck_oen_n  <= !(enabled && master);
			pins.mosi_o     <= shift_ff[7];
			pins.mosi_oen_n <= !(enabled && master && !csr_ff[`CS_SOD]);
			pins.miso_o     <= shift_ff[7];
			pins.miso_oen_n <= !(enabled && !master && !ss_int_n
				&& !csr_ff[`CS_SOD]);
		end
	end

	// APB: no wait state, answer registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite)
				prdata <= hit_data ? {24'h0, rxbuf_ff} :
					hit_ctrl ? {24'h0, ctrl_ff} :
					hit_csr  ? {24'h0, csr_ff} :
					hit_pwr  ? {29'h0, pwr_ff} : 32'h0000_0000;
		end
	end

	// Checks
	tc_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		run && rx_latch_ff |=> csr_ff[`CS_TC]) else $error("complete flag not set");
	ovr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		run && rx_latch_ff && csr_ff[`CS_TC] |=> csr_ff[`CS_OVR]) else $error("overrun missed");
	rxbuf_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		csr_ff[`CS_TC] |=> $stable(rxbuf_ff)) else $error("buffer changed while pending");
	write_collision_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		run && wr_data && busy |=> csr_ff[`CS_WRITE_COLLISION_FLAG]) else $error("collision missed");
	mode_fault_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		run && mf_event |=> csr_ff[`CS_MODE_FAULT_FLAG] && !ctrl_ff[`CR_PE] && !ctrl_ff[`CR_MASTER_SELECT_BIT])
		else $error("fault handling wrong");
	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq |-> $past(ctrl_ff[`CR_IE]) && $past(pwr_ff[`PWR_GIE])) else $error("ungated irq");
	halt_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		halted && $past(halted) |-> $stable(csr_ff) && $stable(ctrl_ff))
		else $error("registers moved in halt");
	sod_a: assert property (@(posedge pclk) disable iff (!presetn)
		csr_ff[`CS_SOD] |=> pins.mosi_oen_n && pins.miso_oen_n) else $error("output not off");
	apb_ans_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> pready) else $error("no bus answer");
	byte_c: cover property (@(posedge pclk) disable iff (!presetn) rx_latch_ff);
	ovr_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(csr_ff[`CS_OVR]));
	mode_fault_flag_c: cover property (@(posedge pclk) disable iff (!presetn) mf_event);
	wake_c: cover property (@(posedge pclk) disable iff (!presetn) wake && halted);
endmodule
`default_nettype wire

// ==== verif/spi_link_partner.sv ====
// Purpose: Far-side serial device, slave to a master block or master to a slave block
// Assumes: Slave role reacts on clock edges directly; half period in clk cycles
// Notes:   Data line left by the master role, or a phase-0 slave, shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none

module spi_link_partner (
	// Clock
	input  wire logic       clk,
	// Mode, kept equal to the block
	input  wire logic       clock_polarity_bit,
	input  wire logic       clock_phase_bit,
	// Wire levels
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       miso,
	// Lines driven by this side
	output logic            sck_m,
	output logic            mosi_m,
	output logic            ss_n_m,
	output logic            miso_s,
	output logic [7:0]      rx_s
);
	logic [7:0] sh;
	logic [3:0] cnt;

	// Idle levels before any frame
	initial begin
		sck_m = 1'b0;
		mosi_m = 1'b1;
		ss_n_m = 1'b1;
		sh = 8'h00;
		cnt = 4'h0;
	end

	assign miso_s = sh[7];

	// Slave role: acts at the wire edge itself, as a real device would;
	// no shift before the first capture, so both phases share one path
	always @(sck) begin
		if ((sck != clock_polarity_bit) ^ clock_phase_bit) begin
			rx_s <= {rx_s[6:0], mosi};
			cnt  <= cnt + 4'h1;
		end else if (cnt != 4'h0) begin
			sh <= {sh[6:0], ~sh[0]};
		end
	end

	// Byte to answer with in the slave role
	task automatic load(input logic [7:0] b);
		@(posedge clk);
		sh  <= b;
		cnt <= 4'h0;
	endtask

	// Select line in the master role
	task automatic select(input logic v);
		@(posedge clk);
		ss_n_m <= v;
	endtask

	// Master role: clock stands at its idle level outside the frame
	task automatic xfer(input logic [7:0] tx, input int half, output logic [7:0] rx);
		@(posedge clk);
		sck_m  <= clock_polarity_bit;
		ss_n_m <= 1'b0;
		mosi_m <= tx[7];
		repeat (half) @(posedge clk);
		for (int i = 7; i >= 0; i--) begin
			sck_m <= ~clock_polarity_bit;
			if (clock_phase_bit) mosi_m <= tx[i];
			else rx[i] = miso;
			repeat (half) @(posedge clk);
			sck_m <= clock_polarity_bit;
			if (clock_phase_bit) rx[i] = miso;
			else if (i > 0) mosi_m <= tx[i-1];
			repeat (half) @(posedge clk);
		end
		mosi_m <= ~tx[0];
		if (!clock_phase_bit) ss_n_m <= 1'b1;
	endtask
endmodule

`default_nettype wire

// ==== verif/tb_spi_master_slave_controller.sv ====
// Purpose: Self-checking bench for the serial controller
// Assumes: Partner model on the link; wire level taken from the driving side
// Notes:   Every wait is bounded; all but the half-period count end the run when they run out
`timescale 1ns/1ps
`default_nettype none
`include "spi_cfg.svh"
`define CHK(what, exp, got) begin n_tests++; \
	if ((got) !== (exp)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", what, exp, got); end end

module tb_spi_master_slave_controller;
	import spi_pkg::*;
	localparam logic [11:0] A_DATA = 12'({`IDX_DATA, 2'b00});
	localparam logic [11:0] A_CTRL = 12'({`IDX_CTRL, 2'b00});
	localparam logic [11:0] A_CSR  = 12'({`IDX_CSR, 2'b00});
	localparam logic [11:0] A_PWR  = 12'({`IDX_PWR, 2'b00});
	localparam logic [11:0] A_BAD  = 12'h1A0;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, wake, err;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata;
	spi_pins_type pins;
	logic         sck_w, mosi_w, miso_w, sck_m, mosi_m, ss_n_m, miso_s, p_clock_polarity_bit, p_clock_phase_bit;
	logic [7:0]   rx_s, q;
	int           bad_count = 0;
	int           n_tests = 0;

	// Wire level from whichever side drives
	assign sck_w  = pins.sck_oen_n ? sck_m : pins.sck_o;
	assign mosi_w = pins.mosi_oen_n ? mosi_m : pins.mosi_o;
	assign miso_w = pins.miso_oen_n ? miso_s : pins.miso_o;

	spi_master_slave_controller i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
		.ss_n_i(ss_n_m), .pins(pins), .irq(irq), .wake(wake));
	spi_link_partner i_partner (.clk(pclk), .clock_polarity_bit(p_clock_polarity_bit), .clock_phase_bit(p_clock_phase_bit), .sck(sck_w),
		.mosi(mosi_w), .miso(miso_w), .sck_m(sck_m), .mosi_m(mosi_m), .ss_n_m(ss_n_m),
		.miso_s(miso_s), .rx_s(rx_s));

	// Clock, 25 ns period
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic guard(input logic ok, input string s);
		if (!ok) begin
			bad_count++;
			$display("[FAIL] %s exp 1 got 0", s);
			close_out();
		end
	endtask

	// One APB transfer; request held until pready is seen
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		guard(pready === 1'b1, "pready");
		q = prdata[7:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdx(input logic [11:0] a, input logic [7:0] e, input string s);
		apb(1'b0, a, 8'h00);
		`CHK(s, e, q)
	endtask

	function automatic int half_of(input logic [2:0] c);
		case (c)
			3'h4: return 2;
			3'h0: return 4;
			3'h1: return 8;
			3'h6: return 16;
			3'h2: return 32;
			default: return 64;
		endcase
	endfunction

	task automatic t_reset;
		rdx(A_CTRL, `CR_RESET, "ctrl reset");
		rdx(A_CSR, `CS_RESET, "csr reset");
		`CHK("pins free", 1'b1, pins.mosi_oen_n)
		wr(A_CSR, 8'hFF);
		rdx(A_CSR, 8'h07, "flags read only");
		apb(1'b0, A_BAD, 8'h00);
		`CHK("unmapped", 1'b1, err)
	endtask

	// Master byte; mode 1 tries a refused write, mode 2 a colliding one
	task automatic t_master(input logic [2:0] c, input logic pol, input logic pha,
		input logic [7:0] tx, input logic [7:0] stx, input int mode);
		int i;
		int n;
		logic v;
		p_clock_polarity_bit <= pol;
		p_clock_phase_bit <= pha;
		wr(A_CTRL, 8'h00);
		wr(A_CSR, 8'h03);
		wr(A_CTRL, {2'b11, c[2], 1'b1, pol, pha, c[1:0]});
		repeat (3) @(posedge pclk);
		`CHK("sck idle", pol, pins.sck_o)
		`CHK("sck driven", 1'b0, pins.sck_oen_n)
		i_partner.load(stx);
		wr(A_DATA, tx);
		for (i = 0; i < 300 && pins.sck_o === pol; i++) @(posedge pclk);
		guard(i < 300, "sck start");
		v = pins.sck_o;
		for (n = 0; n < 200 && pins.sck_o === v; n++) @(posedge pclk);
		`CHK("half period", half_of(c), n)
		if (mode == 2) wr(A_DATA, 8'h55);
		for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge pclk);
		guard(irq === 1'b1, "irq");
		if (mode == 1) wr(A_DATA, 8'h99);
		repeat (10) @(posedge pclk);
		rdx(A_CSR, (mode == 2) ? 8'hC3 : 8'h83, "csr");
		rdx(A_DATA, stx, "rx buffer");
		`CHK("partner rx", tx, rx_s)
		repeat (2) @(posedge pclk);
		`CHK("irq clear", 1'b0, irq)
	endtask

	task automatic t_fault;
		wr(A_PWR, 8'h00);
		wr(A_CSR, 8'h00);
		wr(A_CTRL, 8'hD4);
		i_partner.select(1'b0);
		repeat (6) @(posedge pclk);
		`CHK("masked irq", 1'b0, irq)
		`CHK("outputs off", 1'b1, pins.sck_oen_n)
		wr(A_PWR, 8'h04);
		repeat (3) @(posedge pclk);
		`CHK("fault irq", 1'b1, irq)
		rdx(A_CTRL, 8'h84, "ctrl after fault");
		rdx(A_CSR, 8'h10, "fault flag");
		i_partner.select(1'b1);
		wr(A_CTRL, 8'h00);
		rdx(A_CSR, 8'h00, "fault clear");
	endtask

	task automatic t_slave;
		logic [7:0] r;
		p_clock_polarity_bit <= 1'b0;
		p_clock_phase_bit <= 1'b1;
		wr(A_CSR, 8'h06);
		wr(A_CTRL, 8'hC4);
		repeat (3) @(posedge pclk);
		`CHK("sck input", 1'b1, pins.sck_oen_n)
		`CHK("output off", 1'b1, pins.miso_oen_n)
		wr(A_CSR, 8'h02);
		repeat (3) @(posedge pclk);
		`CHK("output on", 1'b0, pins.miso_oen_n)
		wr(A_DATA, 8'h3C);
		i_partner.xfer(8'h5A, 4, r);
		`CHK("slave tx", 8'h3C, r)
		i_partner.xfer(8'hC3, 4, r);
		rdx(A_CSR, 8'hA2, "overrun");
		rdx(A_DATA, 8'h5A, "kept byte");
		rdx(A_CSR, 8'h02, "overrun clear");
	endtask

	// Wake watched beside the byte, since it may stand only briefly
	task automatic t_power;
		int i;
		logic [7:0] r;
		wr(A_PWR, 8'h05);
		fork
			i_partner.xfer(8'h6B, 4, r);
			for (i = 0; i < 200 && wake !== 1'b1; i++) @(posedge pclk);
		join
		guard(i < 200, "wait wake");
		rdx(A_CSR, 8'h82, "wait flag");
		rdx(A_DATA, 8'h6B, "wait byte");
		wr(A_PWR, 8'h06);
		fork
			i_partner.xfer(8'h4D, 4, r);
			for (i = 0; i < 200 && wake !== 1'b1; i++) @(posedge pclk);
		join
		guard(i < 200, "halt wake");
		rdx(A_PWR, 8'h04, "halt left");
		i_partner.xfer(8'h00, 4, r);
	endtask

	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		p_clock_polarity_bit = 1'b0;
		p_clock_phase_bit = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		wr(A_PWR, 8'h04);
		i_partner.select(1'b0);
		t_master(3'h4, 1'b0, 1'b0, 8'hA5, 8'h3C, 1);
		t_master(3'h0, 1'b0, 1'b1, 8'h81, 8'h7E, 0);
		t_master(3'h1, 1'b1, 1'b0, 8'h5A, 8'hC3, 0);
		t_master(3'h6, 1'b1, 1'b1, 8'h01, 8'hF0, 2);
		t_master(3'h2, 1'b0, 1'b0, 8'h96, 8'h69, 0);
		t_master(3'h3, 1'b1, 1'b1, 8'hE7, 8'h18, 0);
		i_partner.select(1'b1);
		t_fault();
		t_slave();
		t_power();
		close_out();
	end
endmodule

`default_nettype wire
